// ### tdai_regs.vh
// Purpose: constants for the transmit digital audio input port
// Assumes: included by the port module, its checks and the bench; the synchroniser and shifter do not include it
// Notes: register map seen through the plain register port
`ifndef TDAI_REGS_VH
`define TDAI_REGS_VH
`define TDAI_ADDR_W 4
`define TDAI_OFS_CTRL 4'h0
`define TDAI_OFS_RATE 4'h1
`define TDAI_OFS_STAT 4'h2
`define TDAI_OFS_LEFT 4'h3
`define TDAI_OFS_RIGHT 4'h4
`define TDAI_OFS_COUNT 4'h5
`define TDAI_CTRL_FMT_LSB 0
`define TDAI_CTRL_FMT_MSB 1
`define TDAI_CTRL_LEN_LSB 2
`define TDAI_CTRL_LEN_MSB 3
`define TDAI_CTRL_DSPDLY_BIT 4
`define TDAI_CTRL_RST 32'h00000000
`define TDAI_RATE_RST 16'h0000
`define TDAI_FMT_I2S 2'h0
`define TDAI_FMT_LJ 2'h1
`define TDAI_FMT_DSP 2'h2
`define TDAI_LEN_8 2'h0
`define TDAI_LEN_16 2'h1
`define TDAI_LEN_20 2'h2
`define TDAI_LEN_24 2'h3
`define TDAI_RATE_32K 16'd32000
`define TDAI_RATE_40K 16'd40000
`define TDAI_RATE_44K1 16'd44100
`define TDAI_RATE_48K 16'd48000
`define TDAI_STAT_ACTIVE_BIT 0
`define TDAI_STAT_RATE_OK_BIT 1
`define TDAI_STAT_NEW_BIT 2
`endif

// ### tdai_sync2.v
// Purpose: two-flop synchroniser for a pin level
// Assumes: input is asynchronous to clk_in
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module tdai_sync2 (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // level
  input wire async_in,
  output wire sync_out
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // tdai_sync2

// ### tdai_shift.v
// Purpose: msb-first shift register that stops after the word length
// Assumes: shift_in is a one-cycle enable per bit-clock rising edge
// Notes: surplus bits after the lsb are ignored
`timescale 1ns/1ps
module tdai_shift #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // control
  input wire start_in,
  input wire shift_in,
  input wire bit_in,
  input wire [4:0] len_in,
  // result
  output wire [WIDTH-1:0] word_out,
  output wire done_out
);
  reg [WIDTH-1:0] sr_q;
  reg [4:0] cnt_q;
  always @(posedge clk_in) begin
    if (rst_in) begin
      sr_q <= {WIDTH{1'b0}};
      cnt_q <= 5'h00;
    end else if (start_in) begin
      // a bit offered on the start edge itself is the msb
      sr_q <= shift_in ? {{(WIDTH-1){1'b0}}, bit_in} : {WIDTH{1'b0}};
      cnt_q <= shift_in ? 5'h01 : 5'h00;
    end else if (shift_in && cnt_q != len_in) begin
      // msb arrives first; lsb lands in bit 0 after len bits
      sr_q <= {sr_q[WIDTH-2:0], bit_in};
      cnt_q <= cnt_q + 5'h01;
    end
  end
  assign word_out = sr_q;
  assign done_out = (cnt_q == len_in);
endmodule // tdai_shift

// ### tdai_port.v
// Purpose: slave serial audio input port of the transmit path
// Assumes: bit clock and frame sync come from the external master
// Notes: bit clock is sampled by clk_in, so it must be well below 100 MHz
//
// Overview of operation
// - port only listens; clock and sync are inputs
// - i2s msb on second rising edge
// - i2s left while sync low, right high
// - left-justified msb on first rising edge
// - left-justified left while sync high
// - dsp right word follows left immediately
// - dsp msb on second or third edge
// - surplus bit clocks after lsb ignored
// - word length 8, 16, 20 or 24
// - rates 32, 40, 44.1, 48 kHz selectable
// - bit clock above 1 MHz while enabled
// - sample rate resets to zero, disabled
`timescale 1ns/1ps
`include "tdai_regs.vh"
module tdai_port #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // serial audio pins, inputs only
  input wire audio_bit_clock_in,
  input wire audio_frame_sync_in,
  input wire audio_data_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [31:0] reg_rdata_out,
  // stereo sample toward internal processing
  output wire [WIDTH-1:0] left_out,
  output wire [WIDTH-1:0] right_out,
  output wire sample_valid_out
);
  reg [31:0] ctrl_q;
  reg [15:0] rate_q;
  reg [31:0] rdata_q;
  reg [WIDTH-1:0] left_q;
  reg [WIDTH-1:0] right_q;
  reg valid_q;
  reg new_q;
  reg [15:0] count_q;
  reg bclk_d1_q;
  reg fs_prev_q;
  reg fs_seen_q;
  reg chan_q;
  reg [1:0] wait_q;
  reg armed_q;
  reg [WIDTH-1:0] left_hold_q;
  // one-cycle restart of the shifter for the dsp right word
  reg dsp_next_q;
  wire bclk_s;
  wire fs_s;
  wire dat_s;
  wire [1:0] fmt;
  wire [1:0] len_sel;
  wire dsp_late;
  reg [4:0] len;
  wire enabled;
  wire rate_ok;
  wire rise;
  wire fs_edge;
  wire dsp_pulse;
  wire frame_mark;
  wire word_start;
  wire [1:0] start_delay;
  wire [WIDTH-1:0] word;
  wire word_done;
  wire shift_en;
  reg [WIDTH-1:0] word_just;
  wire chan_fs;
  // inputs from the master only; nothing is driven back
  tdai_sync2 u_sync_bclk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(audio_bit_clock_in),
    .sync_out(bclk_s)
  );
  tdai_sync2 u_sync_fs (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(audio_frame_sync_in),
    .sync_out(fs_s)
  );
  tdai_sync2 u_sync_dat (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(audio_data_in),
    .sync_out(dat_s)
  );
  assign fmt = ctrl_q[`TDAI_CTRL_FMT_MSB:`TDAI_CTRL_FMT_LSB];
  assign len_sel = ctrl_q[`TDAI_CTRL_LEN_MSB:`TDAI_CTRL_LEN_LSB];
  assign dsp_late = ctrl_q[`TDAI_CTRL_DSPDLY_BIT];
  // word length selection
  always @* begin
    case (len_sel)
      `TDAI_LEN_8: len = 5'd8;
      `TDAI_LEN_16: len = 5'd16;
      `TDAI_LEN_20: len = 5'd20;
      default: len = 5'd24;
    endcase
  end
  // supported rates; zero disables the port
  assign rate_ok = (rate_q == `TDAI_RATE_32K) ||
                   (rate_q == `TDAI_RATE_40K) ||
                   (rate_q == `TDAI_RATE_44K1) ||
                   (rate_q == `TDAI_RATE_48K);
  assign enabled = rate_ok;
  // the bit clock is oversampled by clk_in, so it has to run fast
  // enough to give clean edges but stay far below clk_in
  // a stopped clock simply yields no edges and no samples
  assign rise = enabled && bclk_s && !bclk_d1_q;
  // frame sync is sampled on bit-clock rising edges
  assign fs_edge = rise && fs_seen_q && (fs_s != fs_prev_q);
  // dsp frame start is the rising edge of the sync pulse
  assign dsp_pulse = rise && fs_s && !fs_prev_q;
  assign frame_mark = (fmt == `TDAI_FMT_DSP) ? dsp_pulse : fs_edge;
  // the mark is the first rising edge that sees the new sync level;
  // start_delay counts edges from it, 1 being the mark edge itself
  // left-justified: msb on the mark edge
  // i2s: msb one edge later, the second edge
  // dsp: the mark sees the pulse, msb one or two edges on
  assign start_delay = (fmt == `TDAI_FMT_I2S) ? 2'd2 :
                       (fmt == `TDAI_FMT_LJ) ? 2'd1 :
                       (dsp_late ? 2'd3 : 2'd2);
  // a delay of 1 captures on the mark, longer ones count armed edges
  assign word_start = rise && (frame_mark ? (start_delay == 2'd1) :
                      (armed_q && wait_q == 2'd1));
  // channel by sync level: i2s left low lj left high
  assign chan_fs = (fmt == `TDAI_FMT_I2S) ? fs_s : !fs_s;
  // bits accepted only inside the word; surplus clocks dropped
  // mark edges belong to word_start, so no stale bit is loaded there
  assign shift_en = rise && !armed_q && !word_done && !frame_mark;
  tdai_shift #(
    .WIDTH(WIDTH)
  ) u_shift (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(frame_mark || dsp_next_q),
    .shift_in(shift_en || word_start),
    .bit_in(dat_s),
    .len_in(len),
    .word_out(word),
    .done_out(word_done)
  );
  // left-justify the received word in the output width
  always @* begin
    word_just = word << (WIDTH - len);
  end
  always @(posedge clk_in) begin
    if (rst_in) begin
      bclk_d1_q <= 1'b0;
      fs_prev_q <= 1'b0;
      fs_seen_q <= 1'b0;
      chan_q <= 1'b0;
      wait_q <= 2'd0;
      armed_q <= 1'b0;
    end else begin
      bclk_d1_q <= bclk_s;
      if (!enabled) begin
        // pins ignored, framing state dropped
        fs_seen_q <= 1'b0;
        armed_q <= 1'b0;
        wait_q <= 2'd0;
        chan_q <= 1'b0;
      end else if (rise) begin
        fs_prev_q <= fs_s;
        fs_seen_q <= 1'b1;
        if (frame_mark) begin
          // armed only when the msb is still some edges away
          armed_q <= (start_delay != 2'd1);
          wait_q <= start_delay - 2'd1;
          chan_q <= (fmt == `TDAI_FMT_DSP) ? 1'b0 : chan_fs;
        end else if (armed_q) begin
          wait_q <= wait_q - 2'd1;
          if (wait_q == 2'd1) begin
            armed_q <= 1'b0;
          end
        end
      end
      // dsp right word runs straight on from the left lsb
      // there is no sync edge for it, so the channel flips here
      if (enabled && dsp_next_q) begin
        chan_q <= 1'b1;
      end
    end
  end
  // word completion pulse: done goes high one cycle after the last shift
  reg done_d1_q;
  wire word_end;
  assign word_end = word_done && !done_d1_q && !frame_mark;
  always @(posedge clk_in) begin
    if (rst_in) begin
      done_d1_q <= 1'b1;
      new_q <= 1'b0;
      left_hold_q <= {WIDTH{1'b0}};
      left_q <= {WIDTH{1'b0}};
      right_q <= {WIDTH{1'b0}};
      valid_q <= 1'b0;
      count_q <= 16'h0000;
    end else begin
      done_d1_q <= word_done;
      valid_q <= 1'b0;
      if (!enabled) begin
        // a held left word must not pair across a disable
        left_hold_q <= {WIDTH{1'b0}};
      end
      if (enabled && word_end) begin
        if (!chan_q) begin
          left_hold_q <= word_just;
        end else begin
          // pair complete: hand over once per frame
          left_q <= left_hold_q;
          right_q <= word_just;
          valid_q <= 1'b1;
          count_q <= count_q + 16'h0001;
        end
      end
      if (reg_rd_in && reg_addr_in == `TDAI_OFS_STAT) begin
        new_q <= 1'b0;
      end
      // set wins over the read clear
      if (enabled && word_end && chan_q) begin
        new_q <= 1'b1;
      end
    end
  end
  // dsp: right word starts right after left lsb, no new mark
  // the restart lands well before the next bit-clock rising edge
  always @(posedge clk_in) begin
    if (rst_in) begin
      dsp_next_q <= 1'b0;
    end else begin
      dsp_next_q <= enabled && fmt == `TDAI_FMT_DSP && word_end && !chan_q;
    end
  end
  // registers; rate resets to zero = disabled
  always @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_q <= `TDAI_CTRL_RST;
      rate_q <= `TDAI_RATE_RST;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `TDAI_OFS_CTRL) begin
        ctrl_q <= {27'h0000000, reg_wdata_in[4:0]};
      end
      if (reg_addr_in == `TDAI_OFS_RATE) begin
        rate_q <= reg_wdata_in[15:0];
      end
    end
  end
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `TDAI_OFS_CTRL: rdata_q <= ctrl_q;
        `TDAI_OFS_RATE: rdata_q <= {16'h0000, rate_q};
        `TDAI_OFS_STAT: rdata_q <= {29'h00000000, new_q, rate_ok, enabled};
        `TDAI_OFS_LEFT: rdata_q <= {{(32-WIDTH){1'b0}}, left_q};
        `TDAI_OFS_RIGHT: rdata_q <= {{(32-WIDTH){1'b0}}, right_q};
        `TDAI_OFS_COUNT: rdata_q <= {16'h0000, count_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end
  assign reg_rdata_out = rdata_q;
  assign left_out = left_q;
  assign right_out = right_q;
  assign sample_valid_out = valid_q;
endmodule // tdai_port

// ### tdai_port_asserts.sv
// Purpose: port-level checks of the audio input port
// Assumes: bound to every tdai_port instance
// Notes: tracks rate, length and new-pair flag in helper flops
`timescale 1ns/1ps
`include "tdai_regs.vh"
module tdai_port_asserts #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  // stereo sample
  input wire [WIDTH-1:0] left_out,
  input wire [WIDTH-1:0] right_out,
  input wire sample_valid_out
);
  reg en_q;
  reg new_q;
  reg [1:0] len_q;
  wire [15:0] rt = reg_wdata_in[15:0];
  wire stat_rd = reg_rd_in && reg_addr_in == `TDAI_OFS_STAT;
  wire [4:0] wl = len_q == 2'h0 ? 5'h08 : len_q == 2'h1 ? 5'h10 :
    len_q == 2'h2 ? 5'h14 : 5'h18;
  wire [WIDTH-1:0] lm = {WIDTH{1'b1}} >> wl;
  always @(posedge clk_in) begin
    if (rst_in) begin
      en_q <= 1'b0;
      new_q <= 1'b0;
      len_q <= 2'h0;
    end else begin
      if (reg_wr_in && reg_addr_in == `TDAI_OFS_RATE)
        en_q <= rt == `TDAI_RATE_32K || rt == `TDAI_RATE_40K ||
          rt == `TDAI_RATE_44K1 || rt == `TDAI_RATE_48K;
      if (reg_wr_in && reg_addr_in == `TDAI_OFS_CTRL)
        len_q <= reg_wdata_in[3:2];
      if (sample_valid_out)
        new_q <= 1'b1;
      else if (stat_rd)
        new_q <= 1'b0;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_reset_quiet: assert property (
    $fell(rst_in) |-> !sample_valid_out && left_out == 0)
    else $error("outputs not quiet after reset");
  a_valid_gap: assert property (
    sample_valid_out |=> !sample_valid_out [*8])
    else $error("sample valid not a lone pulse");
  a_pair_held: assert property (
    $changed(left_out) || $changed(right_out) |-> sample_valid_out)
    else $error("pair changed without valid");
  a_disabled_quiet: assert property (
    !en_q && !$past(en_q) |-> !sample_valid_out)
    else $error("sample delivered while disabled");
  a_stat_enable: assert property (
    stat_rd |=> reg_rdata_out[1:0] == {2{$past(en_q)}})
    else $error("status enable bits wrong");
  a_len_mask: assert property (
    sample_valid_out |-> ((left_out | right_out) & lm) == 0)
    else $error("bits below word length set");
  a_stat_new: assert property (
    stat_rd && !sample_valid_out && !$past(sample_valid_out)
    |=> reg_rdata_out[2] == $past(new_q))
    else $error("new pair flag wrong");
  a_rdata_idle: assert property (
    !reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data outside read slot");
  c_pair: cover property (sample_valid_out);
  c_new_seen: cover property (stat_rd ##1 reg_rdata_out[2]);
  c_bad_rate: cover property (en_q ##1 !en_q);
endmodule // tdai_port_asserts

bind tdai_port tdai_port_asserts #(.WIDTH(WIDTH)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .left_out(left_out), .right_out(right_out),
  .sample_valid_out(sample_valid_out));

// ### tdai_master_model.sv
// Purpose: serial audio master driving clock, sync and data
// Assumes: bit clock runs free at 48 ns as long as the port may be enabled
// Notes: unused slots carry toggling junk data
`timescale 1ns/1ps
module tdai_master_model (
  // pins toward the port
  output reg bclk_out,
  output reg fs_out,
  output reg data_out
);
  // clock and sync come only from here
  initial begin
    bclk_out = 1'b0;
    fs_out = 1'b0;
    data_out = 1'b0;
    #7;
    forever #24 bclk_out = ~bclk_out;
  end
  task slot(input f, input j, input d);
    begin
      @(negedge bclk_out);
      fs_out <= f;
      data_out <= j ? ~data_out : d;
    end
  endtask
  // w is left-justified; msb first down to lsb
  task chan(input f, input integer skip, input integer len,
    input [23:0] w, input integer tail);
    integer k;
    begin
      for (k = 0; k < skip; k = k + 1) slot(f, 1'b1, 1'b0);
      for (k = 23; k > 23 - len; k = k - 1) slot(f, 1'b0, w[k]);
      for (k = 0; k < tail; k = k + 1) slot(f, 1'b1, 1'b0);
    end
  endtask
  task frame(input [1:0] fmt, input late, input integer len,
    input [23:0] l, input [23:0] r);
    begin
      if (fmt == 2'h2) begin
        slot(1'b1, 1'b1, 1'b0);
        chan(1'b0, late, len, l, 0);
        chan(1'b0, 0, len, r, 3);
      end else begin
        chan(fmt == 2'h1, fmt == 2'h0, len, l, 2);
        chan(fmt != 2'h1, fmt == 2'h0, len, r, 2);
      end
    end
  endtask
endmodule // tdai_master_model

// ### tdai_port_tb_top.sv
// Purpose: self-checking bench of the audio input port
// Assumes: master model drives the serial pins
// Notes: each format setting, dsp once per delay, runs with two word lengths and its own rate
`timescale 1ns/1ps
`include "tdai_regs.vh"
module tdai_port_tb_top;
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [3:0] reg_addr_in = 4'h0;
  reg [31:0] reg_wdata_in = 32'h0;
  reg reg_wr_in = 1'b0;
  reg reg_rd_in = 1'b0;
  wire [31:0] reg_rdata_out;
  wire [23:0] left_out;
  wire [23:0] right_out;
  wire sample_valid_out;
  wire bclk;
  wire fs;
  wire sd;
  integer mismatches = 0;
  integer checks = 0;
  integer cycles = 0;
  integer i, f, lc, len, rt, c0;
  reg live = 1'b0;
  reg [47:0] exp_q [$];
  reg [31:0] rd;
  reg [23:0] l, r;
  always #2.5 clk_in = ~clk_in;
  tdai_port u_tdai_port (.clk_in(clk_in), .rst_in(rst_in),
    .audio_bit_clock_in(bclk), .audio_frame_sync_in(fs),
    .audio_data_in(sd), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .left_out(left_out), .right_out(right_out),
    .sample_valid_out(sample_valid_out));
  tdai_master_model u_tdai_master_model (.bclk_out(bclk), .fs_out(fs),
    .data_out(sd));
  task check(input [47:0] got, input [47:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (mismatches == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rdr(input [3:0] a);
    begin
      @(posedge clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      #1 rd = reg_rdata_out;
    end
  endtask
  task send;
    begin
      l = $urandom & ~(24'hffffff >> len);
      r = $urandom & ~(24'hffffff >> len);
      if (live) exp_q.push_back({l, r});
      u_tdai_master_model.frame(f == 3 ? 2 : f, f == 3, len, l, r);
    end
  endtask
  always @(posedge clk_in) begin
    if (sample_valid_out === 1'b1 && live) begin
      if (exp_q.size() == 0) check(48'h1, 48'h0);
      else check({left_out, right_out}, exp_q.pop_front());
    end
  end
  always @(posedge clk_in) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  initial begin
    void'($urandom(62));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rdr(`TDAI_OFS_CTRL); check(rd, 32'h0);
    rdr(`TDAI_OFS_RATE); check(rd, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      live = 1'b0;
      f = i % 4;
      lc = (i + i / 4) % 4;
      len = lc == 0 ? 8 : lc == 1 ? 16 : 4 * lc + 12;
      rt = f == 0 ? 32000 : f == 1 ? 40000 : f == 2 ? 44100 : 48000;
      wr(`TDAI_OFS_RATE, 32'h0);
      wr(`TDAI_OFS_CTRL, (f == 3) * 16 + lc * 4 + (f == 3 ? 2 : f));
      wr(`TDAI_OFS_RATE, rt);
      rdr(`TDAI_OFS_RATE); check(rd, rt);
      repeat (2) send;
      repeat (200) @(posedge clk_in);
      rdr(`TDAI_OFS_COUNT);
      c0 = rd;
      rdr(`TDAI_OFS_STAT); check(rd[1:0], 2'h3);
      live = 1'b1;
      repeat (3) send;
      repeat (200) @(posedge clk_in);
      check(exp_q.size(), 0);
      rdr(`TDAI_OFS_COUNT); check(rd - c0, 3);
      rdr(`TDAI_OFS_STAT); check(rd[2], 1'b1);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr(`TDAI_OFS_RATE, i * 12345);
      rdr(`TDAI_OFS_STAT); check(rd[1:0], 2'h0);
      live = 1'b0;
      repeat (2) send;
      live = 1'b1;
    end
    repeat (200) @(posedge clk_in);
    // a full reset while enabled returns rate and status registers to zero
    wr(`TDAI_OFS_RATE, `TDAI_RATE_48K);
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    rdr(`TDAI_OFS_RATE); check(rd, 32'h0);
    rdr(`TDAI_OFS_STAT); check(rd, 32'h0);
    rdr(4'h9); check(rd, 32'h0);
    finish_test;
  end
endmodule // tdai_port_tb_top
